// >>> hw/mdk_pkg.sv
// Purpose: Shared constants for the mode and downlink keying controller
// Assumes: 100 MHz system clock, one clock domain
// Notes:   Times are kept in hours, minutes or seconds; counts derive from them
package mdk_pkg;
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned TICK_S     = 1;
  localparam int unsigned SEC_CYCLES = CLK_HZ * TICK_S;
  localparam int unsigned TICK_W     = 27;

  localparam int unsigned MIN_S        = 60;
  localparam int unsigned HOUR_S       = 3600;
  localparam int unsigned DATA_TO_H    = 24;
  localparam int unsigned HANG_MIN     = 2;
  localparam int unsigned IDLE_MIN     = 2;
  localparam int unsigned BCN_LEAD_SEC = 5;
  localparam int unsigned BCN_TAIL_SEC = 6;
  localparam int unsigned TST_GAP_SEC  = 1;

  localparam int unsigned DCNT_W = 17;
  localparam int unsigned TCNT_W = 7;
  localparam int unsigned WCNT_W = 3;
  localparam logic [DCNT_W-1:0] DATA_TO_CNT = DCNT_W'(DATA_TO_H * HOUR_S);
  localparam logic [TCNT_W-1:0] HANG_CNT    = TCNT_W'(HANG_MIN * MIN_S);
  localparam logic [TCNT_W-1:0] IDLE_CNT    = TCNT_W'(IDLE_MIN * MIN_S);
  // One extra tick so a wait never ends short of its figure
  localparam logic [WCNT_W-1:0] BCN_LEAD_CNT = WCNT_W'(BCN_LEAD_SEC + 1);
  localparam logic [WCNT_W-1:0] BCN_TAIL_CNT = WCNT_W'(BCN_TAIL_SEC + 1);
  localparam logic [WCNT_W-1:0] TST_GAP_CNT  = WCNT_W'(TST_GAP_SEC + 1);

  localparam int unsigned MIX_W = 3;
  localparam logic [MIX_W-1:0] MIX_RX_LS  = 3'h0;
  localparam logic [MIX_W-1:0] MIX_SIL    = 3'h1;
  localparam logic [MIX_W-1:0] MIX_LS_BCN = 3'h2;
  localparam logic [MIX_W-1:0] MIX_LS_SIL = 3'h3;
  localparam logic [MIX_W-1:0] MIX_TST_LS = 3'h4;
  localparam logic [MIX_W-1:0] MIX_HS     = 3'h5;
  localparam logic [MIX_W-1:0] MIX_TST    = 3'h6;

  localparam logic [1:0] CMD_XPDR = 2'h0;
  localparam logic [1:0] CMD_DATA = 2'h1;
  localparam logic [1:0] CMD_CLR  = 2'h2;
  localparam logic [1:0] CMD_TEST = 2'h3;

  localparam int unsigned PIN_W   = 7;
  localparam int unsigned PIN_STB = 4;
  localparam int unsigned PIN_SQ  = 5;
  localparam int unsigned PIN_USB = 6;

  localparam logic [7:0] REG_CMD   = 8'h00;
  localparam logic [7:0] REG_STAT  = 8'h04;
  localparam logic [7:0] REG_DLEFT = 8'h08;
  localparam int unsigned ST_MODE = 0;
  localparam int unsigned ST_KEY  = 1;
  localparam int unsigned ST_MIX  = 2;
  localparam int unsigned ST_HANG = 5;
  localparam int unsigned ST_IDLE = 6;
  localparam int unsigned ST_USB  = 7;
  localparam int unsigned ST_SEQ  = 8;
  localparam logic HRESP_OKAY = 1'h0;

  typedef enum logic [3:0] {
    SQ_LISTEN, SQ_BCN_LEAD, SQ_BCN_SEND, SQ_BCN_TAIL, SQ_TST_LEAD, SQ_TST_SEND,
    SQ_TST_TAIL, SQ_DAT_RUN, SQ_DAT_PRE, SQ_DAT_SEND, SQ_DAT_POST
  } mdk_seq_e;
endpackage

// >>> hw/mdk_tick_if.sv
// Purpose: Carries the one-second tick between prescaler and controller
// Assumes: Same clock on both ends
// Notes:   Tick is a one-cycle pulse
interface mdk_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface

// >>> hw/mdk_tick_gen.sv
// Purpose: Prescaler giving a one-second tick from the system clock
// Assumes: Period set by the top module parameter
// Notes:   Free running; reset clears it and the other timers, but loads the idle timer with IDLE_CNT
module mdk_tick_gen #(
  parameter int unsigned TICK_CYCLES = mdk_pkg::SEC_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Tick out
  mdk_tick_if.src  tk
);
  import mdk_pkg::*;
  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic              tick;
  } mdk_tick_s;
  mdk_tick_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == TICK_W'(TICK_CYCLES - 1)) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tk.tick = s_q.tick;
endmodule

// >>> hw/mdk_ctrl.sv
// Purpose: Operating mode keeper and downlink keying sequencer
// Assumes: Pins are asynchronous; message player runs on clk_sys_in
// Notes:   Registers on AHB-Lite, zero wait states, always OKAY
//
// Decided for this implementation: the AHB-Lite register port and the address map.
module mdk_ctrl #(
  parameter int unsigned TICK_CYCLES = mdk_pkg::SEC_CYCLES
) (
  // Clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      rst_in,
  // Command decoder and radio pins
  input  wire logic [3:0]                cmd_bits_in,
  input  wire logic                      cmd_strobe_in,
  input  wire logic                      squelch_tone_detect_in,
  input  wire logic                      usb_power_in,
  // Stored message player
  input  wire logic                      beacon_sent_in,
  input  wire logic                      test_sent_in,
  // Radio and telemetry
  output logic                           transmit_key_out,
  output logic [mdk_pkg::MIX_W-1:0]      mixer_src_out,
  output logic                           operating_mode_out,
  output logic                           clear_minmax_out,
  // AHB-Lite slave
  input  wire logic                      hsel_in,
  input  wire logic [31:0]               haddr_in,
  input  wire logic [1:0]                htrans_in,
  input  wire logic                      hwrite_in,
  input  wire logic [2:0]                hsize_in,
  input  wire logic [31:0]               hwdata_in,
  input  wire logic                      hready_in,
  output logic                           hreadyout_out,
  output logic                           hresp_out,
  output logic [31:0]                    hrdata_out
);
  import mdk_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0]  sy1;
    logic [PIN_W-1:0]  sy2;
    logic              stb3;
    logic              mode;
    logic              key_want;
    logic              key;
    logic [MIX_W-1:0]  mix;
    logic              clr_req;
    logic              test_pend;
    logic              diag_pend;
    logic [1:0]        diag_cmd;
    mdk_seq_e          seq;
    logic [DCNT_W-1:0] data_cnt;
    logic              hang_run;
    logic [TCNT_W-1:0] hang_cnt;
    logic              idle_run;
    logic [TCNT_W-1:0] idle_cnt;
    logic [WCNT_W-1:0] wait_cnt;
    logic              wr_pend;
    logic [7:0]        waddr;
    logic              hready;
    logic              hresp;
    logic [31:0]       hrdata;
  } mdk_ctrl_s;

  mdk_ctrl_s  s_q, s_d;
  mdk_tick_if tk_if ();
  logic       dec_new;
  logic       cmd_ok;
  logic [1:0] cmd;
  logic       go_xpdr;
  logic       acc;

  mdk_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .tk         (tk_if.src)
  );

  always_comb begin
    s_d = s_q;
    // First stage feeds only the second stage
    s_d.sy1 = {usb_power_in, squelch_tone_detect_in, cmd_strobe_in, cmd_bits_in};
    s_d.sy2 = s_q.sy1;
    s_d.stb3 = s_q.sy2[PIN_STB];
    s_d.clr_req = 1'b0;
    dec_new = s_q.sy2[PIN_STB] & ~s_q.stb3;
    // Upper decoder bits act in separate hardware, so only 1:0 matter
    cmd = dec_new ? s_q.sy2[1:0] : s_q.diag_cmd;
    cmd_ok = dec_new | s_q.diag_pend;
    if (!dec_new) begin
      s_d.diag_pend = 1'b0;
    end
    go_xpdr = 1'b0;

    // Bus slave: address phase captured, write data taken one cycle later
    acc = hsel_in & htrans_in[1] & hready_in;
    s_d.wr_pend = acc & hwrite_in;
    s_d.waddr = haddr_in[7:0];
    s_d.hrdata = '0;
    if (acc && !hwrite_in) begin
      if (haddr_in[7:0] == REG_STAT) begin
        s_d.hrdata[ST_MODE] = s_q.mode;
        s_d.hrdata[ST_KEY] = s_q.key;
        s_d.hrdata[ST_MIX +: MIX_W] = s_q.mix;
        s_d.hrdata[ST_HANG] = s_q.hang_run;
        s_d.hrdata[ST_IDLE] = s_q.idle_run;
        s_d.hrdata[ST_USB] = s_q.sy2[PIN_USB];
        s_d.hrdata[ST_SEQ +: 4] = s_q.seq;
      end else if (haddr_in[7:0] == REG_DLEFT) begin
        s_d.hrdata[DCNT_W-1:0] = s_q.data_cnt;
      end
    end
    if (s_q.wr_pend && s_q.waddr == REG_CMD) begin
      s_d.diag_pend = 1'b1;
      s_d.diag_cmd = hwdata_in[1:0];
    end

    // Shared one-second tick drives every timer
    if (tk_if.tick) begin
      if (s_q.wait_cnt != '0) begin
        s_d.wait_cnt = s_q.wait_cnt - 1'b1;
      end
      if (s_q.hang_run && s_q.hang_cnt != '0) begin
        s_d.hang_cnt = s_q.hang_cnt - 1'b1;
      end
      if (s_q.idle_run && s_q.idle_cnt != '0) begin
        s_d.idle_cnt = s_q.idle_cnt - 1'b1;
      end
      if (s_q.mode && s_q.data_cnt != '0) begin
        s_d.data_cnt = s_q.data_cnt - 1'b1;
      end
    end

    // Sequencer; commands below override it
    case (s_q.seq)
      SQ_LISTEN: begin
        if (s_q.test_pend) begin
          s_d.test_pend = 1'b0;
          s_d.key_want = 1'b1;
          s_d.wait_cnt = TST_GAP_CNT;
          s_d.seq = SQ_TST_LEAD;
        end else if (s_q.sy2[PIN_SQ]) begin
          s_d.key_want = 1'b1;
          s_d.hang_run = 1'b1;
          s_d.hang_cnt = HANG_CNT;
          s_d.idle_run = 1'b0;
        end else if (s_q.hang_run && s_q.hang_cnt == '0) begin
          s_d.hang_run = 1'b0;
          s_d.key_want = 1'b0;
          s_d.idle_run = 1'b1;
          s_d.idle_cnt = IDLE_CNT;
        end else if (s_q.idle_run && s_q.idle_cnt == '0) begin
          s_d.idle_run = 1'b0;
          s_d.mix = MIX_SIL;
          s_d.key_want = 1'b1;
          s_d.wait_cnt = BCN_LEAD_CNT;
          s_d.seq = SQ_BCN_LEAD;
        end
      end
      SQ_BCN_LEAD: begin
        if (s_q.wait_cnt == '0) begin
          s_d.mix = MIX_LS_BCN;
          s_d.seq = SQ_BCN_SEND;
        end
      end
      SQ_BCN_SEND: begin
        if (beacon_sent_in) begin
          s_d.mix = MIX_LS_SIL;
          s_d.wait_cnt = BCN_TAIL_CNT;
          s_d.seq = SQ_BCN_TAIL;
        end
      end
      SQ_BCN_TAIL: begin
        if (s_q.wait_cnt == '0) begin
          s_d.key_want = 1'b0;
          s_d.mix = MIX_RX_LS;
          s_d.idle_run = 1'b1;
          s_d.idle_cnt = IDLE_CNT;
          s_d.seq = SQ_LISTEN;
        end
      end
      SQ_TST_LEAD: begin
        if (s_q.wait_cnt == '0) begin
          s_d.mix = MIX_TST_LS;
          s_d.seq = SQ_TST_SEND;
        end
      end
      SQ_TST_SEND: begin
        if (test_sent_in) begin
          // A live hang timer means a user is talking: stay keyed
          if (!s_q.hang_run) begin
            s_d.wait_cnt = TST_GAP_CNT;
            s_d.seq = SQ_TST_TAIL;
          end else begin
            s_d.mix = MIX_RX_LS;
            s_d.seq = SQ_LISTEN;
          end
        end
      end
      SQ_TST_TAIL: begin
        if (s_q.wait_cnt == '0) begin
          s_d.key_want = 1'b0;
          s_d.mix = MIX_RX_LS;
          s_d.seq = SQ_LISTEN;
        end
      end
      SQ_DAT_RUN: begin
        if (s_q.test_pend) begin
          s_d.test_pend = 1'b0;
          s_d.mix = MIX_SIL;
          s_d.wait_cnt = TST_GAP_CNT;
          s_d.seq = SQ_DAT_PRE;
        end
      end
      SQ_DAT_PRE: begin
        if (s_q.wait_cnt == '0) begin
          s_d.mix = MIX_TST;
          s_d.seq = SQ_DAT_SEND;
        end
      end
      SQ_DAT_SEND: begin
        if (test_sent_in) begin
          s_d.mix = MIX_SIL;
          s_d.wait_cnt = TST_GAP_CNT;
          s_d.seq = SQ_DAT_POST;
        end
      end
      SQ_DAT_POST: begin
        if (s_q.wait_cnt == '0) begin
          s_d.mix = MIX_HS;
          s_d.seq = SQ_DAT_RUN;
        end
      end
      default: begin
        s_d.seq = SQ_LISTEN;
      end
    endcase

    // Commands
    if (cmd_ok) begin
      case (cmd)
        CMD_XPDR: begin
          s_d.data_cnt = '0;
          go_xpdr = s_q.mode;
        end
        CMD_DATA: begin
          s_d.data_cnt = DATA_TO_CNT;
          if (!s_q.mode) begin
            s_d.mode = 1'b1;
            s_d.mix = MIX_HS;
            s_d.key_want = 1'b1;
            s_d.seq = SQ_DAT_RUN;
            s_d.wait_cnt = '0;
            s_d.hang_run = 1'b0;
            s_d.idle_run = 1'b0;
          end
        end
        CMD_CLR: begin
          s_d.clr_req = 1'b1;
        end
        default: begin
          s_d.test_pend = 1'b1;
        end
      endcase
    end
    if (s_q.mode && s_q.data_cnt == '0 && !(cmd_ok && cmd == CMD_DATA)) begin
      go_xpdr = 1'b1;
    end
    if (go_xpdr) begin
      s_d.mode = 1'b0;
      s_d.data_cnt = '0;
      s_d.key_want = 1'b0;
      s_d.mix = MIX_RX_LS;
      s_d.seq = SQ_LISTEN;
      s_d.wait_cnt = '0;
      s_d.test_pend = 1'b0;
      s_d.hang_run = 1'b0;
      s_d.idle_run = 1'b1;
      s_d.idle_cnt = IDLE_CNT;
    end
    // Gate at the last flop so no path can key on USB power
    s_d.key = s_d.key_want & ~s_q.sy2[PIN_USB];
    s_d.hready = 1'b1;
    s_d.hresp = HRESP_OKAY;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
      s_q.hready <= 1'b1;
      s_q.idle_run <= 1'b1;
      s_q.idle_cnt <= IDLE_CNT;
    end else begin
      s_q <= s_d;
    end
  end

  assign transmit_key_out   = s_q.key;
  assign mixer_src_out      = s_q.mix;
  assign operating_mode_out = s_q.mode;
  assign clear_minmax_out   = s_q.clr_req;
  assign hreadyout_out      = s_q.hready;
  assign hresp_out          = s_q.hresp;
  assign hrdata_out         = s_q.hrdata;

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  chk_usb_no_key: assert property (s_q.sy2[PIN_USB] |=> !transmit_key_out)
    else $error("key raised while on USB power");
  chk_xpdr_cmd: assert property (cmd_ok && cmd == CMD_XPDR |=> !operating_mode_out
    && s_q.data_cnt == '0)
    else $error("transponder command did not stop data mode");
  chk_data_cmd: assert property (cmd_ok && cmd == CMD_DATA |=> operating_mode_out
    && s_q.data_cnt == DATA_TO_CNT)
    else $error("data command did not load timeout");
  chk_data_expire: assert property (operating_mode_out && s_q.data_cnt == '0
    && !cmd_ok |=> !operating_mode_out)
    else $error("data mode outlived its timeout");
  chk_clr_pulse: assert property (cmd_ok && cmd == CMD_CLR |=> clear_minmax_out
    ##1 (!clear_minmax_out || $past(cmd_ok)))
    else $error("clear request not a single pulse");
  chk_enter_data: assert property ($rose(operating_mode_out) |-> mixer_src_out == MIX_HS
    && transmit_key_out == !$past(s_q.sy2[PIN_USB]))
    else $error("data entry mixer or key wrong");
  chk_leave_data: assert property ($fell(operating_mode_out) |-> !transmit_key_out
    && mixer_src_out == MIX_RX_LS && s_q.seq == SQ_LISTEN)
    else $error("transponder entry did not unkey");
  chk_squelch_hang: assert property (s_q.seq == SQ_LISTEN && !s_q.test_pend
    && s_q.sy2[PIN_SQ] && !cmd_ok |=> s_q.hang_run && s_q.hang_cnt == HANG_CNT
    && !s_q.idle_run)
    else $error("squelch did not reload hang timer");
  chk_hang_expire: assert property (s_q.seq == SQ_LISTEN && !s_q.test_pend
    && !s_q.sy2[PIN_SQ] && s_q.hang_run && s_q.hang_cnt == '0 && !cmd_ok
    |=> !transmit_key_out && s_q.idle_run && s_q.idle_cnt == IDLE_CNT)
    else $error("hang expiry did not start idle timer");
  chk_bcn_order: assert property (s_q.seq == SQ_BCN_SEND && beacon_sent_in && !cmd_ok
    |=> mixer_src_out == MIX_LS_SIL ##1 s_q.seq == SQ_BCN_TAIL)
    else $error("beacon tail not entered");
endmodule

// >>> bench/mdk_player_model.sv
// Purpose: Stored message player standing beside the controller
// Assumes: Same clock as the controller
// Notes:   Alternates a short and a long message so both prompt and slow ends occur
module mdk_player_model #(
  parameter int unsigned FAST_CYC = 5,
  parameter int unsigned SLOW_CYC = 90
) (
  // Clock and reset
  input  wire logic                         clk_sys_in,
  input  wire logic                         rst_in,
  // Mixer selection seen
  input  wire logic [mdk_pkg::MIX_W-1:0]    mixer_src_in,
  // Completion pulses
  output logic                              beacon_sent_out,
  output logic                              test_sent_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import mdk_pkg::*;
  logic        busy;
  logic        fired_q;
  logic        slow_q;
  int unsigned cnt_q;

  assign busy = (mixer_src_in == MIX_LS_BCN) || (mixer_src_in == MIX_TST_LS) ||
                (mixer_src_in == MIX_TST);

  // One pulse per selection; a pulse never repeats while the source is held
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q           <= 0;
      fired_q         <= 1'b0;
      slow_q          <= 1'b0;
      beacon_sent_out <= 1'b0;
      test_sent_out   <= 1'b0;
    end else begin
      beacon_sent_out <= 1'b0;
      test_sent_out   <= 1'b0;
      if (!busy) begin
        cnt_q   <= 0;
        fired_q <= 1'b0;
      end else if (!fired_q) begin
        cnt_q <= cnt_q + 1;
        if (cnt_q == (slow_q ? SLOW_CYC : FAST_CYC)) begin
          fired_q         <= 1'b1;
          slow_q          <= !slow_q;
          beacon_sent_out <= (mixer_src_in == MIX_LS_BCN);
          test_sent_out   <= (mixer_src_in != MIX_LS_BCN);
        end
      end
    end
  end
endmodule

// >>> bench/tb_top.sv
// Purpose: Self-checking bench for the mode and downlink keying controller
// Assumes: Tick shortened to 20 clock cycles; data timeout too long to run out
// Notes:   Each scenario is one task; sequence steps are awaited, never timed
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import mdk_pkg::*;
  localparam int TK = 20;
  localparam int LIMIT = 20000;

  logic        clk_sys_in;
  logic        rst_in;
  logic [3:0]  cmd_bits;
  logic        strobe;
  logic        squelch;
  logic        usb;
  logic        bcn_sent;
  logic        tst_sent;
  logic        transmit_key_out;
  logic [2:0]  mixer_src_out;
  logic        operating_mode_out;
  logic        clear_minmax_out;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout_out;
  logic        hresp_out;
  logic [31:0] hrdata_out;
  int          err_count;
  int          num_checks;
  int          cycles;
  int          clr_cnt;

  mdk_ctrl #(.TICK_CYCLES(TK)) uut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_bits_in(cmd_bits),
    .cmd_strobe_in(strobe), .squelch_tone_detect_in(squelch), .usb_power_in(usb),
    .beacon_sent_in(bcn_sent), .test_sent_in(tst_sent),
    .transmit_key_out(transmit_key_out), .mixer_src_out(mixer_src_out),
    .operating_mode_out(operating_mode_out), .clear_minmax_out(clear_minmax_out),
    .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .hrdata_out(hrdata_out));

  mdk_player_model player (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .mixer_src_in(mixer_src_out),
    .beacon_sent_out(bcn_sent), .test_sent_out(tst_sent));

  always #5 clk_sys_in = !clk_sys_in;

  always @(posedge clk_sys_in) begin
    cycles++;
    if (clear_minmax_out === 1'b1) clr_cnt++;
    if (cycles == LIMIT) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bus master: address phase held until hready, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_sys_in);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask

  task automatic reg_cmd(input logic [1:0] c);
    logic [31:0] rd;
    bus(1'b1, REG_CMD, {30'h0, c}, rd);
  endtask

  // Bits settle before the strobe rises, as the decoder does
  task automatic dec(input logic [3:0] b);
    @(posedge clk_sys_in);
    cmd_bits <= b;
    repeat (4) @(posedge clk_sys_in);
    strobe <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    strobe <= 1'b0;
  endtask

  task automatic wait_st(input string what, input logic k, input logic [2:0] m,
                         input int lim, output int el);
    el = 0;
    #1;
    while (!(transmit_key_out === k && mixer_src_out === m) && el < lim) begin
      @(posedge clk_sys_in);
      #1;
      el++;
    end
    check({what, " key"}, 32'(transmit_key_out), 32'(k));
    check({what, " mixer"}, 32'(mixer_src_out), 32'(m));
  endtask

  task automatic t_reset();
    check("reset mode", 32'(operating_mode_out), 32'h0);
    check("reset key", 32'(transmit_key_out), 32'h0);
    check("reset mixer", 32'(mixer_src_out), 32'(MIX_RX_LS));
    check("hresp", 32'(hresp_out), 32'(HRESP_OKAY));
    check("hready", 32'(hreadyout_out), 32'h1);
  endtask

  task automatic t_usb();
    int el;
    usb <= 1'b1;
    dec(4'hD);
    wait_st("usb data", 1'b0, MIX_HS, 40, el);
    check("usb mode", 32'(operating_mode_out), 32'h1);
    dec(4'h0);
    wait_st("usb xpdr", 1'b0, MIX_RX_LS, 40, el);
    @(posedge clk_sys_in);
    usb <= 1'b0;
    dec(4'h1);
    wait_st("data", 1'b1, MIX_HS, 40, el);
  endtask

  task automatic t_dleft();
    logic [31:0] d1;
    logic [31:0] d2;
    logic [31:0] d3;
    bus(1'b0, REG_DLEFT, 32'h0, d1);
    repeat (3 * TK) @(posedge clk_sys_in);
    bus(1'b0, REG_DLEFT, 32'h0, d2);
    check("dleft runs", 32'(d2 < d1), 32'h1);
    reg_cmd(CMD_DATA);
    bus(1'b0, REG_DLEFT, 32'h0, d3);
    check("dleft reload", d3, 32'(DATA_TO_CNT));
    bus(1'b0, REG_STAT, 32'h0, d3);
    check("status mode", 32'(d3[ST_MODE]), 32'h1);
    bus(1'b0, 8'h0C, 32'h0, d3);
    check("unmapped", d3, 32'h0);
  endtask

  task automatic t_data_test();
    int el;
    dec(4'h3);
    wait_st("dt pre", 1'b1, MIX_SIL, 40, el);
    wait_st("dt msg", 1'b1, MIX_TST, 3 * TK, el);
    check("dt gap", 32'(el >= TK - 2), 32'h1);
    wait_st("dt post", 1'b1, MIX_SIL, 200, el);
    wait_st("dt back", 1'b1, MIX_HS, 3 * TK, el);
    check("dt gap2", 32'(el >= TK - 2), 32'h1);
  endtask

  task automatic t_clear();
    int c0;
    c0 = clr_cnt;
    dec(4'h2);
    repeat (10) @(posedge clk_sys_in);
    check("clear pulse", 32'(clr_cnt - c0), 32'h1);
    check("clear mode", 32'(operating_mode_out), 32'h1);
  endtask

  task automatic t_xpdr();
    int el;
    reg_cmd(CMD_XPDR);
    wait_st("xpdr", 1'b0, MIX_RX_LS, 20, el);
    check("xpdr mode", 32'(operating_mode_out), 32'h0);
    reg_cmd(CMD_TEST);
    wait_st("xt msg", 1'b1, MIX_TST_LS, 3 * TK, el);
    wait_st("xt end", 1'b0, MIX_RX_LS, 200, el);
  endtask

  task automatic t_squelch();
    int el;
    @(posedge clk_sys_in);
    squelch <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    wait_st("sq key", 1'b1, MIX_RX_LS, 10, el);
    repeat (10) @(posedge clk_sys_in);
    squelch <= 1'b0;
    wait_st("hang end", 1'b0, MIX_RX_LS, 125 * TK, el);
    check("hang len", 32'(el >= 119 * TK - 5), 32'h1);
    wait_st("bcn lead", 1'b1, MIX_SIL, 125 * TK, el);
    check("idle len", 32'(el >= 119 * TK - 5), 32'h1);
    wait_st("bcn send", 1'b1, MIX_LS_BCN, 7 * TK, el);
    check("bcn lead len", 32'(el >= 5 * TK - 2), 32'h1);
    wait_st("bcn tail", 1'b1, MIX_LS_SIL, 200, el);
    wait_st("bcn done", 1'b0, MIX_RX_LS, 8 * TK, el);
    check("bcn tail len", 32'(el >= 6 * TK - 2), 32'h1);
  endtask

  initial begin
    clk_sys_in = 1'b0;
    rst_in     = 1'b1;
    cmd_bits   = 4'h0;
    strobe     = 1'b0;
    squelch    = 1'b0;
    usb        = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hwdata     = 32'h0;
    err_count  = 0;
    num_checks = 0;
    cycles     = 0;
    clr_cnt    = 0;
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    t_reset();
    t_usb();
    t_dleft();
    t_data_test();
    t_clear();
    t_xpdr();
    t_squelch();
    end_of_test();
  end
endmodule
